/* hbti_consts.svh */
`ifndef HBTI_CONSTS_SVH
`define HBTI_CONSTS_SVH
`define HBTI_ADDR_W 9
`define HBTI_DATA_W 16
`define HBTI_NUM_TX 3
`define HBTI_NUM_SRC 6
`define HBTI_VEC_W 8
`define HBTI_VEC_BASE 8'h40
`define HBTI_READ_LAT 2
`define HBTI_ACK_DELAY 2'h2
`endif

/* hbti_pkg.sv */
package hbti_pkg;
  typedef enum logic [1:0] {
    HBTI_IDLE,
    HBTI_WAIT,
    HBTI_ACK
  } hbti_state_type;
  typedef enum logic {
    HBTI_REG_CYCLE,
    HBTI_IACK_CYCLE
  } hbti_cycle_type;
endpackage

/* hbti_tx_prio.sv */
`timescale 1ns/1ps
`include "hbti_consts.svh"
module hbti_tx_prio #(
  parameter int NUM_TX = `HBTI_NUM_TX,
  parameter logic [7:0] VEC_BASE = `HBTI_VEC_BASE
) (
  input wire logic [2*NUM_TX-1:0] i_pending,
  output logic o_any,
  output logic [7:0] o_vector
);
  // Channel 0 has the highest priority; each channel has its own vector.
  always_comb begin
    o_any = |i_pending;
    o_vector = VEC_BASE;
    for (int c = NUM_TX - 1; c >= 0; c--) begin
      if (i_pending[2*c] || i_pending[2*c+1]) begin
        o_vector = VEC_BASE + 8'(c);
      end
    end
  end
endmodule

/* hbti_host_port.sv */
`timescale 1ns/1ps
`include "hbti_consts.svh"
// How it works
// - Nine select lines pick exactly one register per access.
// - Sixteen-bit data bus: host writes, device drives on reads.
// - Acknowledge cycle puts the vector on data bits 0 to 7 only.
// - Register accesses are ignored while chip select is high.
// - Lower strobe qualifies data bits 0 to 7.
// - Upper strobe qualifies data bits 8 to 15.
// - Direction high means read, low means write.
// - On reads, acknowledge only after read data is valid.
// - On writes, acknowledge signals the data was accepted.
// - Acknowledge only in a selected access or acknowledge cycle.
// - Transmit request is open drain, low while anything pends.
// - Six sources: queue empty and end of transmission per channel.
// - Acknowledge input with active request starts a vector cycle.
// - Vector belongs to the highest priority requesting channel.
// - Each channel has its own vector.
// - Answer acknowledge only while the chain input is low.
// - Chain output low only if chain input low and nothing pends.
module hbti_host_port #(
  parameter int ADDR_W = `HBTI_ADDR_W,
  parameter int DATA_W = `HBTI_DATA_W,
  parameter int NUM_TX = `HBTI_NUM_TX
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [ADDR_W-1:0] i_register_select_lines,
  input wire logic [DATA_W-1:0] i_host_data_lines,
  output logic [DATA_W-1:0] o_host_data_lines,
  output logic [DATA_W-1:0] o_host_data_lines_oe_n,
  input wire logic i_chip_select_n,
  input wire logic i_lower_byte_strobe_n,
  input wire logic i_upper_byte_strobe_n,
  input wire logic i_read_not_write,
  output logic o_transfer_ack,
  output logic o_transfer_ack_oe_n,
  output logic o_tx_irq_req,
  output logic o_tx_irq_req_oe_n,
  input wire logic i_tx_irq_ack_n,
  input wire logic i_tx_chain_in_n,
  output logic o_tx_chain_out_n,
  input wire logic [NUM_TX-1:0] i_tx_queue_empty,
  input wire logic [NUM_TX-1:0] i_tx_end_of_tx,
  output logic [ADDR_W-1:0] o_reg_addr,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [DATA_W-1:0] o_reg_wdata,
  output logic [1:0] o_reg_byte_en,
  input wire logic [DATA_W-1:0] i_reg_rdata,
  output logic o_iack_taken
);
  logic [ADDR_W-1:0] a_s1, a_s2;
  logic [DATA_W-1:0] d_s1, d_s2;
  logic [4:0] c_s1, c_s2;
  logic cs_n, lds_n, uds_n, rnw, iack_n, chain_n;
  logic [2*NUM_TX-1:0] pending;
  logic any_pend;
  logic [7:0] vector;
  logic strobe, reg_req, iack_req, active;
  logic [1:0] wait_cnt;
  logic [DATA_W-1:0] rdata;
  logic drive_lo, drive_hi, ack;
  hbti_pkg::hbti_state_type state;
  hbti_pkg::hbti_cycle_type cyc;

  // Host pins are asynchronous, so every one passes two flops first.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      a_s1 <= '0;
      a_s2 <= '0;
      d_s1 <= '0;
      d_s2 <= '0;
      c_s1 <= 5'h1F;
      c_s2 <= 5'h1F;
    end else begin
      a_s1 <= i_register_select_lines;
      a_s2 <= a_s1;
      d_s1 <= i_host_data_lines;
      d_s2 <= d_s1;
      c_s1 <= {i_chip_select_n, i_lower_byte_strobe_n,
               i_upper_byte_strobe_n, i_read_not_write, i_tx_irq_ack_n};
      c_s2 <= c_s1;
    end
  end

  logic chain_s1;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      chain_s1 <= 1'b1;
      chain_n <= 1'b1;
    end else begin
      chain_s1 <= i_tx_chain_in_n;
      chain_n <= chain_s1;
    end
  end

  assign {cs_n, lds_n, uds_n, rnw, iack_n} = c_s2;

  // Interleave sources: bit 2c is queue empty, bit 2c+1 end of transmission.
  always_comb begin
    for (int c = 0; c < NUM_TX; c++) begin
      pending[2*c] = i_tx_queue_empty[c];
      pending[2*c+1] = i_tx_end_of_tx[c];
    end
  end

  hbti_tx_prio #(
    .NUM_TX(NUM_TX),
    .VEC_BASE(`HBTI_VEC_BASE)
  ) u_prio (
    .i_pending(pending),
    .o_any(any_pend),
    .o_vector(vector)
  );

  assign strobe = !lds_n || !uds_n;
  assign reg_req = !cs_n && strobe;
  assign iack_req = !iack_n && any_pend && !chain_n && strobe;
  assign active = reg_req || (!iack_n && strobe);

  // The byte lanes are taken from the strobes only when the cycle starts, so a host that
  // changes them mid cycle sees the byte lanes chosen at the start.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= hbti_pkg::HBTI_IDLE;
      cyc <= hbti_pkg::HBTI_REG_CYCLE;
      wait_cnt <= 2'h0;
      rdata <= '0;
      drive_lo <= 1'b0;
      drive_hi <= 1'b0;
      ack <= 1'b0;
      o_reg_addr <= '0;
      o_reg_wr <= 1'b0;
      o_reg_rd <= 1'b0;
      o_reg_wdata <= '0;
      o_reg_byte_en <= 2'h0;
      o_iack_taken <= 1'b0;
    end else begin
      o_reg_wr <= 1'b0;
      o_reg_rd <= 1'b0;
      o_iack_taken <= 1'b0;
      unique case (state)
        hbti_pkg::HBTI_IDLE: begin
          if (reg_req) begin
            cyc <= hbti_pkg::HBTI_REG_CYCLE;
            o_reg_addr <= a_s2;
            o_reg_byte_en <= {!uds_n, !lds_n};
            o_reg_wdata <= d_s2;
            o_reg_wr <= !rnw;
            o_reg_rd <= rnw;
            wait_cnt <= `HBTI_ACK_DELAY;
            state <= hbti_pkg::HBTI_WAIT;
          end else if (iack_req) begin
            cyc <= hbti_pkg::HBTI_IACK_CYCLE;
            o_iack_taken <= 1'b1;
            rdata <= {8'h00, vector};
            drive_lo <= 1'b1;
            drive_hi <= 1'b0;
            wait_cnt <= `HBTI_ACK_DELAY;
            state <= hbti_pkg::HBTI_WAIT;
          end
        end
        hbti_pkg::HBTI_WAIT: begin
          if (!active) begin
            drive_lo <= 1'b0;
            drive_hi <= 1'b0;
            state <= hbti_pkg::HBTI_IDLE;
          end else if (wait_cnt == 2'h1) begin
            if (cyc == hbti_pkg::HBTI_REG_CYCLE && rnw) begin
              rdata <= i_reg_rdata;
              drive_lo <= o_reg_byte_en[0];
              drive_hi <= o_reg_byte_en[1];
            end
            state <= hbti_pkg::HBTI_ACK;
          end else begin
            wait_cnt <= wait_cnt - 2'h1;
          end
        end
        hbti_pkg::HBTI_ACK: begin
          ack <= 1'b1;
          if (!active) begin
            ack <= 1'b0;
            drive_lo <= 1'b0;
            drive_hi <= 1'b0;
            state <= hbti_pkg::HBTI_IDLE;
          end
        end
        default: state <= hbti_pkg::HBTI_IDLE;
      endcase
    end
  end

  assign o_host_data_lines = rdata;
  assign o_host_data_lines_oe_n = {{(DATA_W/2){!drive_hi}},
                                   {(DATA_W/2){!drive_lo}}};
  // Open-drain pins: the output is always low, only the enable moves.
  assign o_transfer_ack = 1'b0;
  assign o_transfer_ack_oe_n = !ack;
  assign o_tx_irq_req = 1'b0;
  assign o_tx_irq_req_oe_n = !any_pend;
  assign o_tx_chain_out_n = !(!chain_n && !any_pend);

  property p_ack_sel;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      ack |-> $past(active);
  endproperty
  a_ack_sel: assert property (p_ack_sel)
    else $error("Acknowledge outside a selected cycle.");

  property p_irq;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      o_tx_irq_req_oe_n == !(|{i_tx_queue_empty, i_tx_end_of_tx});
  endproperty
  a_irq: assert property (p_irq)
    else $error("Transmit request does not follow the sources.");

  property p_chain;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      !o_tx_chain_out_n |-> !chain_n && !any_pend;
  endproperty
  a_chain: assert property (p_chain)
    else $error("Chain output low while pending.");

  property p_vec_lo;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      ack && cyc == hbti_pkg::HBTI_IACK_CYCLE |->
        &o_host_data_lines_oe_n[15:8] && !o_host_data_lines_oe_n[0];
  endproperty
  a_vec_lo: assert property (p_vec_lo)
    else $error("Vector not on low byte only.");

  property p_iack_chain;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      o_iack_taken |-> $past(!chain_n) && $past(any_pend);
  endproperty
  a_iack_chain: assert property (p_iack_chain)
    else $error("Acknowledge cycle taken without chain grant.");

  property p_rd_valid;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      o_reg_rd |-> !ack ##2 (state == hbti_pkg::HBTI_ACK || !active);
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("Read acknowledge timing wrong.");

  property p_release;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      ack && !active |=> !ack ##0 &o_host_data_lines_oe_n;
  endproperty
  a_release: assert property (p_release)
    else $error("Bus not released after cycle end.");

  property p_no_cs;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      cs_n |=> !o_reg_wr && !o_reg_rd;
  endproperty
  a_no_cs: assert property (p_no_cs)
    else $error("Access without chip select.");

  property p_lanes;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      o_reg_wr |-> o_reg_byte_en == $past({!uds_n, !lds_n});
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("Byte enables do not match strobes.");
endmodule

/* hbti_host_model.sv */
`timescale 1ns/1ps
module hbti_host_model (
  input wire logic i_ref_clk,
  input wire logic i_ack_n,
  input wire logic [15:0] i_bus,
  output logic [8:0] o_addr,
  output logic [15:0] o_data,
  output logic o_cs_n,
  output logic o_lds_n,
  output logic o_uds_n,
  output logic o_rnw,
  output logic o_iack_n
);
  initial begin
    o_addr = 9'h000;
    o_data = 16'h0000;
    o_cs_n = 1'b1;
    o_lds_n = 1'b1;
    o_uds_n = 1'b1;
    o_rnw = 1'b1;
    o_iack_n = 1'b1;
  end
  // Released data lines flip so a stale value can never pass for a match.
  task automatic cyc(input logic sel, input logic iack, input logic rnw,
      input logic [8:0] a, input logic [15:0] wd, input logic [1:0] st,
      output logic [15:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 16'h0000;
    @(posedge i_ref_clk);
    #1;
    o_addr = a;
    o_rnw = rnw;
    o_data = rnw ? ~o_data : wd;
    o_cs_n = !sel;
    o_iack_n = !iack;
    o_uds_n = !st[1];
    o_lds_n = !st[0];
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge i_ref_clk);
      ok = (i_ack_n === 1'b0);
      rd = i_bus;
    end
    #1;
    o_cs_n = 1'b1;
    o_iack_n = 1'b1;
    o_lds_n = 1'b1;
    o_uds_n = 1'b1;
    o_data = ~o_data;
    for (n = 0; n < 10 && i_ack_n !== 1'b1; n++) @(posedge i_ref_clk);
    repeat (2) @(posedge i_ref_clk);
  endtask
endmodule

/* tb.sv */
`timescale 1ns/1ps
`include "hbti_consts.svh"
module tb;
  logic clk, nrst, cs_n, lds_n, uds_n, rnw, iack_n, cin_n, ok;
  logic ack, ack_oe_n, irq, irq_oe_n, cout_n, rwr, rrd, itk;
  logic [8:0] addr, raddr;
  logic [15:0] hd, bus, od, oe_n, wdat, rdat, r, oe_ack;
  logic [2:0] qe, eot;
  logic [1:0] ben;
  int err_count, cmp_count, wr_cnt, rd_cnt, ik_cnt;
  wire logic ack_n = ack_oe_n ? 1'b1 : ack;
  assign bus = (~oe_n & od) | (oe_n & hd);
  assign rdat = {7'h00, raddr} ^ 16'h5a3c;
  always @(posedge clk) begin
    if (rwr === 1'b1) wr_cnt++;
    if (rrd === 1'b1) rd_cnt++;
    if (itk === 1'b1) ik_cnt++;
    if (ack_n === 1'b0) oe_ack <= oe_n;
  end
  hbti_host_model host (.i_ref_clk(clk), .i_ack_n(ack_n), .i_bus(bus),
    .o_addr(addr), .o_data(hd), .o_cs_n(cs_n), .o_lds_n(lds_n),
    .o_uds_n(uds_n), .o_rnw(rnw), .o_iack_n(iack_n));
  hbti_host_port dut (.i_ref_clk(clk), .i_nrst(nrst),
    .i_register_select_lines(addr), .i_host_data_lines(bus),
    .o_host_data_lines(od), .o_host_data_lines_oe_n(oe_n),
    .i_chip_select_n(cs_n), .i_lower_byte_strobe_n(lds_n),
    .i_upper_byte_strobe_n(uds_n), .i_read_not_write(rnw),
    .o_transfer_ack(ack), .o_transfer_ack_oe_n(ack_oe_n),
    .o_tx_irq_req(irq), .o_tx_irq_req_oe_n(irq_oe_n),
    .i_tx_irq_ack_n(iack_n), .i_tx_chain_in_n(cin_n),
    .o_tx_chain_out_n(cout_n), .i_tx_queue_empty(qe),
    .i_tx_end_of_tx(eot), .o_reg_addr(raddr), .o_reg_wr(rwr),
    .o_reg_rd(rrd), .o_reg_wdata(wdat), .o_reg_byte_en(ben),
    .i_reg_rdata(rdat), .o_iack_taken(itk));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    $display("errors=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_reg();
    host.cyc(1, 0, 0, 9'h1a5, 16'hbeef, 2'b11, r, ok);
    chk(ok, 1);
    chk(wr_cnt, 1);
    chk(raddr, 9'h1a5);
    chk(wdat, 16'hbeef);
    chk(ben, 2'b11);
    host.cyc(1, 0, 0, 9'h011, 16'h1234, 2'b10, r, ok);
    chk(ben, 2'b10);
    host.cyc(1, 0, 1, 9'h0c3, 16'h0000, 2'b01, r, ok);
    chk(ok, 1);
    chk(r[7:0], 8'h3c ^ 8'hc3);
    chk(oe_ack, 16'hff00);
    chk(oe_n, 16'hffff);
    host.cyc(1, 0, 1, 9'h100, 16'h0000, 2'b11, r, ok);
    chk(r, 16'h5b3c);
    host.cyc(0, 0, 0, 9'h055, 16'h4321, 2'b11, r, ok);
    chk(ok, 0);
    chk(wr_cnt, 2);
    chk(raddr, 9'h100);
    chk(16'(rd_cnt), 16'h0002);
  endtask
  task automatic t_irq();
    for (int ch = 2; ch >= 0; ch--) begin
      #1 qe[ch] = 1'b1;
      host.cyc(0, 1, 1, 9'h000, 16'h0000, 2'b01, r, ok);
      chk(ok, 1);
      chk(r[7:0], `HBTI_VEC_BASE + 8'(ch));
      chk(oe_ack, 16'hff00);
      chk(irq_oe_n, 0);
      chk(irq, 1'b0);
      chk(cout_n, 1);
    end
    #1 qe = 3'b000;
    eot = 3'b100;
    host.cyc(0, 1, 1, 9'h000, 16'h0000, 2'b01, r, ok);
    chk(r[7:0], `HBTI_VEC_BASE + 8'h02);
    #1 cin_n = 1'b1;
    repeat (4) @(posedge clk);
    host.cyc(0, 1, 1, 9'h000, 16'h0000, 2'b01, r, ok);
    chk(ok, 0);
    chk(cout_n, 1);
    #1 eot = 3'b000;
    cin_n = 1'b0;
    repeat (4) @(posedge clk);
    chk(irq_oe_n, 1);
    chk(cout_n, 0);
    host.cyc(0, 1, 1, 9'h000, 16'h0000, 2'b01, r, ok);
    chk(ok, 0);
    chk(16'(ik_cnt), 16'h0004);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #20000;
    err_count++;
    end_sim();
  end
  initial begin
    nrst = 1'b0;
    cin_n = 1'b0;
    qe = 3'b000;
    eot = 3'b000;
    repeat (3) @(posedge clk);
    #1 nrst = 1'b1;
    t_reg();
    t_irq();
    end_sim();
  end
endmodule
